// ### src/fpmc_pkg.sv
// Shared constants and types of the front panel menu controller.
package fpmc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned SESSION_IDLE_S   = 30;
  localparam int unsigned GAIN_IDLE_S      = 12;
  localparam int unsigned BOOT_PHASE_MS    = 1000;
  localparam int unsigned DEBOUNCE_MS      = 10;
  localparam int unsigned SESSION_IDLE_CYC = SESSION_IDLE_S * CLK_HZ;
  localparam int unsigned GAIN_IDLE_CYC    = GAIN_IDLE_S * CLK_HZ;
  localparam int unsigned BOOT_PHASE_CYC   = BOOT_PHASE_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_MS * (CLK_HZ / 1000);

  // ---------------------------------------------------------------
  // Settings layout and limits
  // ---------------------------------------------------------------
  // Gain is kept as attenuation in 0.5 dB units: 0 is 0 dB, 40 is -20 dB.
  localparam logic [5:0] GAIN_ATT_MAX = 6'h28;
  localparam logic [5:0] GAIN_STEP_10 = 6'h14;
  localparam logic [5:0] GAIN_STEP_1  = 6'h02;
  localparam logic [5:0] GAIN_STEP_H  = 6'h01;
  localparam logic [4:0] ADDR_MAX     = 5'h1f;
  localparam logic [4:0] ADDR_STEP_10 = 5'h0a;
  localparam logic [4:0] ADDR_STEP_1  = 5'h01;
  localparam int unsigned CFG_W       = 14;

  typedef struct packed {
    logic [5:0] gain_att;
    logic       remote_on;
    logic       ext_ref;
    logic       rmode;
    logic [4:0] bus_addr;
  } fpmc_cfg_s;

  // Cursor position of the return marker per kind of item.
  localparam logic [1:0] CUR_RET_GAIN = 2'h3;
  localparam logic [1:0] CUR_RET_ADDR = 2'h2;
  localparam logic [1:0] CUR_RET_FLAG = 2'h1;

  // ---------------------------------------------------------------
  // Switches
  // ---------------------------------------------------------------
  localparam int unsigned SW_COMMIT = 0;
  localparam int unsigned SW_LEFT   = 1;
  localparam int unsigned SW_RIGHT  = 2;
  localparam int unsigned SW_UP     = 3;
  localparam int unsigned SW_DOWN   = 4;
  localparam int unsigned SW_NUM    = 5;

  // ---------------------------------------------------------------
  // Menu states
  // ---------------------------------------------------------------
  typedef enum logic [10:0] {
    ST_BOOT_SEG  = 11'h001,
    ST_BOOT_VER  = 11'h002,
    ST_BOOT_STAT = 11'h004,
    ST_NORMAL    = 11'h008,
    ST_GAIN      = 11'h010,
    ST_REMOTE    = 11'h020,
    ST_EXTREF    = 11'h040,
    ST_RMODE     = 11'h080,
    ST_ADDR      = 11'h100,
    ST_SAVE      = 11'h200,
    ST_DONE      = 11'h400
  } fpmc_state_e;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_STATUS  = 5'h00;
  localparam logic [4:0] REG_ACTIVE  = 5'h04;
  localparam logic [4:0] REG_SAVED   = 5'h08;
  localparam logic [4:0] REG_VERSION = 5'h0c;
  localparam logic [4:0] REG_CTRL    = 5'h10;
  localparam logic [1:0] CTRL_RST    = 2'h0;
  localparam int unsigned CTRL_LOCK  = 0;
  localparam int unsigned CTRL_ATEST = 1;

endpackage : fpmc_pkg

// ### src/fpmc_debounce.sv
// Switch synchroniser and debouncer giving one pulse per press.
`timescale 1ns/1ps
`default_nettype none

module fpmc_debounce
  import fpmc_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Switch
  input  wire logic raw,
  output logic      press
);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        s3;
    logic        stable;
    logic [31:0] cnt;
    logic        press;
  } fpmc_deb_s;

  fpmc_deb_s s;
  fpmc_deb_s next_s;

  always_comb begin
    next_s       = s;
    next_s.s1    = raw;
    next_s.s2    = s.s1;
    next_s.s3    = s.s2;
    next_s.press = 1'b0;
    // A level counts only while the last two stages agree and hold long enough.
    if (s.s2 == s.s3 && s.s3 != s.stable) begin
      if (s.cnt >= 32'(DEB_CYCLES - 1)) begin
        next_s.stable = s.s3;
        next_s.cnt    = '0;
        next_s.press  = s.s3;
      end else begin
        next_s.cnt = s.cnt + 32'h1;
      end
    end else begin
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign press = s.press;

endmodule : fpmc_debounce

`default_nettype wire

// ### src/fpmc_top.sv
// Front panel menu controller: switches, menu sequence, settings, lamps.
//
// Operation
// - Settings change only when commit opens and commit closes via save dialog.
// - About 30 s idle in a session abandons it and restores settings.
// - About 12 s idle in gain menu returns to normal, dropping gain edits.
// - Saved settings are held in non-volatile store and reloaded at power-up.
// - Power-up shows all segments, then version, then status, then accepts input.
// - Each horizontal press moves the cursor one place left or right.
// - Each vertical press raises or lowers the digit under the cursor.
// - On on/off items a vertical press inverts the state either way.
// - Gain step is 10 dB, 1 dB or 0.5 dB by cursor place.
// - Gain is held between 0 dB and -20 dB.
// - Gain edits act at once but are stored only on a yes save.
// - Yes stores, no restores; a further commit leaves the dialog.
// - Commit goes to next item, or on the return marker to save.
// - Items run gain, remote, reference, remote mode, address, save.
// - Alarm lamp lights while any oscillator loop reports loss of lock.
// - Remote lamp lights exactly while remote operation is selected.
// - Bus address stays within 0 to 31.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module fpmc_top
  import fpmc_pkg::*;
#(
  parameter int unsigned SESSION_IDLE_CYCLES = SESSION_IDLE_CYC,
  parameter int unsigned GAIN_IDLE_CYCLES    = GAIN_IDLE_CYC,
  parameter int unsigned BOOT_PHASE_CYCLES   = BOOT_PHASE_CYC,
  parameter int unsigned DEBOUNCE_CYCLES     = DEBOUNCE_CYC,
  // Firmware version shown at power-up; the value is arbitrary.
  parameter logic [31:0] FW_VERSION          = 32'h0000_0100
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Avalon-MM slave
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Front panel switches, high while pressed
  input  wire logic              sw_commit,
  input  wire logic              sw_left,
  input  wire logic              sw_right,
  input  wire logic              sw_up,
  input  wire logic              sw_down,
  // Oscillator lock reports, high while unlocked
  input  wire logic [1:0]        pll_unlock,
  // Non-volatile settings store
  input  wire logic [CFG_W-1:0]  nv_rd_data,
  output logic                   nv_wr_en,
  output logic      [CFG_W-1:0]  nv_wr_data,
  // Settings in force
  output logic      [5:0]        gain_att,
  output logic                   remote_on,
  output logic                   ext_ref_sel,
  output logic                   remote_mode,
  output logic      [4:0]        bus_addr,
  // Display
  output logic      [10:0]       disp_state,
  output logic      [1:0]        disp_cursor,
  output logic                   disp_yes,
  // Lamps
  output logic                   power_lamp,
  output logic                   alarm_led,
  output logic                   remote_led
);

  // ---------------------------------------------------------------
  // Switch conditioning
  // ---------------------------------------------------------------
  logic [SW_NUM-1:0] sw_raw;
  logic [SW_NUM-1:0] sw_press;

  assign sw_raw[SW_COMMIT] = sw_commit;
  assign sw_raw[SW_LEFT]   = sw_left;
  assign sw_raw[SW_RIGHT]  = sw_right;
  assign sw_raw[SW_UP]     = sw_up;
  assign sw_raw[SW_DOWN]   = sw_down;

  for (genvar i = 0; i < SW_NUM; i++) begin : g_sw
    fpmc_debounce #(
      .DEB_CYCLES (DEBOUNCE_CYCLES)
    ) u_deb (
      .clk   (clk),
      .nrst  (nrst),
      .raw   (sw_raw[i]),
      .press (sw_press[i])
    );
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    fpmc_state_e st;
    logic [1:0]  cur;
    logic        yes;
    logic        loaded;
    fpmc_cfg_s   saved;
    fpmc_cfg_s   work;
    logic [31:0] idle;
    logic [31:0] boot;
    logic [1:0]  pll_s1;
    logic [1:0]  pll_s2;
    logic [1:0]  pll_s3;
    logic [1:0]  pll_f;
    logic [1:0]  ctrl;
    logic        ack;
    logic [31:0] rdata;
    logic        nv_we;
    logic        lamp;
    logic        alarm;
  } fpmc_core_s;

  fpmc_core_s s;
  fpmc_core_s next_s;

  // Clamp a stored image so a corrupt store cannot push gain out of range.
  function automatic fpmc_cfg_s cfg_clean(input fpmc_cfg_s c);
    fpmc_cfg_s r;
    r = c;
    if (c.gain_att > GAIN_ATT_MAX) begin
      r.gain_att = GAIN_ATT_MAX;
    end
    return r;
  endfunction : cfg_clean

  function automatic logic [1:0] cur_ret(input fpmc_state_e st);
    logic [1:0] r;
    case (st)
      ST_GAIN: r = CUR_RET_GAIN;
      ST_ADDR: r = CUR_RET_ADDR;
      default: r = CUR_RET_FLAG;
    endcase
    return r;
  endfunction : cur_ret

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [SW_NUM-1:0] ev;
  logic              any_ev;
  logic              in_session;
  logic              bus_req;

  assign ev         = s.ctrl[CTRL_LOCK] ? '0 : sw_press;
  assign any_ev     = |ev;
  assign in_session = (s.st & ~(ST_BOOT_SEG | ST_BOOT_VER |
                                ST_BOOT_STAT | ST_NORMAL)) != '0;
  assign bus_req    = avs_read | avs_write;

  always_comb begin
    logic [6:0]  g7;
    logic [5:0]  gstep;
    logic [5:0]  astep;
    logic [31:0] idle_lim;
    logic        timeout;
    logic        vert;

    g7       = '0;
    gstep    = GAIN_STEP_H;
    astep    = ADDR_STEP_1;
    idle_lim = 32'(SESSION_IDLE_CYCLES);
    timeout  = 1'b0;
    vert     = ev[SW_UP] | ev[SW_DOWN];

    next_s       = s;
    next_s.nv_we = 1'b0;
    next_s.lamp  = 1'b1;

    // Lock reports are asynchronous; a bit changes once stages two and three agree.
    next_s.pll_s1 = pll_unlock;
    next_s.pll_s2 = s.pll_s1;
    next_s.pll_s3 = s.pll_s2;
    for (int b = 0; b < 2; b++) begin
      if (s.pll_s2[b] == s.pll_s3[b]) begin
        next_s.pll_f[b] = s.pll_s3[b];
      end
    end
    next_s.alarm = (|s.pll_f) | s.ctrl[CTRL_ATEST];

    // First cycle after reset: take the stored settings as the active ones.
    if (!s.loaded) begin
      next_s.loaded = 1'b1;
      next_s.saved  = cfg_clean(fpmc_cfg_s'(nv_rd_data));
      next_s.work   = cfg_clean(fpmc_cfg_s'(nv_rd_data));
    end

    // Inactivity counter, cleared by any press and outside sessions.
    if (any_ev || !in_session) begin
      next_s.idle = '0;
    end else if (s.idle != '1) begin
      next_s.idle = s.idle + 32'h1;
    end
    if (s.st == ST_GAIN) begin
      idle_lim = 32'(GAIN_IDLE_CYCLES);
    end
    timeout = in_session && (s.idle >= idle_lim);

    case (s.cur)
      2'h0:    gstep = GAIN_STEP_10;
      2'h1:    gstep = GAIN_STEP_1;
      default: gstep = GAIN_STEP_H;
    endcase
    astep = (s.cur == 2'h0) ? 6'(ADDR_STEP_10) : 6'(ADDR_STEP_1);

    case (s.st)
      ST_BOOT_SEG, ST_BOOT_VER, ST_BOOT_STAT: begin
        // Input is ignored until the three display phases are over.
        if (s.boot >= 32'(BOOT_PHASE_CYCLES - 1)) begin
          next_s.boot = '0;
          case (s.st)
            ST_BOOT_SEG: next_s.st = ST_BOOT_VER;
            ST_BOOT_VER: next_s.st = ST_BOOT_STAT;
            default:     next_s.st = ST_NORMAL;
          endcase
        end else begin
          next_s.boot = s.boot + 32'h1;
        end
      end
      ST_NORMAL: begin
        if (ev[SW_COMMIT]) begin
          next_s.st   = ST_GAIN;
          next_s.cur  = 2'h0;
          next_s.work = s.saved;
        end
      end
      ST_SAVE: begin
        if (vert) begin
          next_s.yes = ~s.yes;
        end
        if (ev[SW_COMMIT]) begin
          next_s.st = ST_DONE;
          if (s.yes) begin
            next_s.saved = s.work;
            next_s.nv_we = 1'b1;
          end else begin
            next_s.work = s.saved;
          end
        end
      end
      ST_DONE: begin
        if (ev[SW_COMMIT]) begin
          next_s.st = ST_NORMAL;
        end
      end
      ST_GAIN, ST_REMOTE, ST_EXTREF, ST_RMODE, ST_ADDR: begin
        if (ev[SW_LEFT] && s.cur != 2'h0) begin
          next_s.cur = s.cur - 2'h1;
        end else if (ev[SW_RIGHT] && s.cur != cur_ret(s.st)) begin
          next_s.cur = s.cur + 2'h1;
        end
        if (vert && s.cur != cur_ret(s.st)) begin
          case (s.st)
            ST_GAIN: begin
              // Up raises gain, which lowers attenuation.
              if (ev[SW_UP]) begin
                next_s.work.gain_att = (s.work.gain_att > gstep) ?
                  s.work.gain_att - gstep : 6'h00;
              end else begin
                g7 = {1'b0, s.work.gain_att} + {1'b0, gstep};
                next_s.work.gain_att = (g7 > {1'b0, GAIN_ATT_MAX}) ?
                  GAIN_ATT_MAX : g7[5:0];
              end
            end
            ST_REMOTE: next_s.work.remote_on = ~s.work.remote_on;
            ST_EXTREF: next_s.work.ext_ref   = ~s.work.ext_ref;
            ST_RMODE:  next_s.work.rmode     = ~s.work.rmode;
            default: begin
              if (ev[SW_UP]) begin
                g7 = {2'h0, s.work.bus_addr} + {1'b0, astep};
                next_s.work.bus_addr = (g7 > {2'h0, ADDR_MAX}) ?
                  ADDR_MAX : g7[4:0];
              end else begin
                next_s.work.bus_addr = ({1'b0, s.work.bus_addr} > astep) ?
                  s.work.bus_addr - astep[4:0] : 5'h00;
              end
            end
          endcase
        end
        if (ev[SW_COMMIT]) begin
          next_s.cur = 2'h0;
          next_s.yes = 1'b1;
          if (s.cur == cur_ret(s.st)) begin
            next_s.st = ST_SAVE;
          end else begin
            case (s.st)
              ST_GAIN:   next_s.st = ST_REMOTE;
              ST_REMOTE: next_s.st = ST_EXTREF;
              ST_EXTREF: next_s.st = ST_RMODE;
              ST_RMODE:  next_s.st = ST_ADDR;
              default:   next_s.st = ST_SAVE;
            endcase
          end
        end
      end
      default: begin
        next_s.st = ST_NORMAL;
      end
    endcase

    // Idle abandonment overrides a press in the same cycle, except that a yes save still stores; the press clears the counter only for the next cycle.
    if (timeout) begin
      next_s.st   = ST_NORMAL;
      next_s.work = s.saved;
      next_s.cur  = 2'h0;
    end

    // Bus answers one cycle after the request is seen.
    next_s.ack = bus_req && !s.ack;
    if (bus_req && !s.ack) begin
      case (avs_address)
        REG_STATUS:  next_s.rdata = {16'h0, s.alarm, in_session, s.yes,
                                     s.cur, s.st};
        REG_ACTIVE:  next_s.rdata = {18'h0, s.work.gain_att, s.saved.remote_on,
                                     s.saved.ext_ref, s.saved.rmode,
                                     s.saved.bus_addr};
        REG_SAVED:   next_s.rdata = {18'h0, s.saved};
        REG_VERSION: next_s.rdata = FW_VERSION;
        REG_CTRL:    next_s.rdata = {30'h0, s.ctrl};
        default:     next_s.rdata = '0;
      endcase
    end
    if (avs_write && s.ack && avs_address == REG_CTRL && avs_byteenable[0]) begin
      next_s.ctrl = avs_writedata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s      <= '0;
      s.st   <= ST_BOOT_SEG;
      s.ctrl <= CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign avs_waitrequest = bus_req & ~s.ack;
  assign avs_readdata    = s.rdata;
  assign nv_wr_en        = s.nv_we;
  assign nv_wr_data      = s.saved;
  // Gain follows the edit copy so changes are heard while adjusting.
  assign gain_att        = s.work.gain_att;
  assign remote_on       = s.saved.remote_on;
  assign ext_ref_sel     = s.saved.ext_ref;
  assign remote_mode     = s.saved.rmode;
  assign bus_addr        = s.saved.bus_addr;
  assign disp_state      = s.st;
  assign disp_cursor     = s.cur;
  assign disp_yes        = s.yes;
  assign power_lamp      = s.lamp;
  assign alarm_led       = s.alarm;
  assign remote_led      = s.saved.remote_on;

endmodule : fpmc_top

`default_nettype wire

// ### tb/fpmc_top_properties.sv
// Port-level assertions for the front panel menu controller.
`timescale 1ns/1ps
`default_nettype none

module fpmc_top_properties
  import fpmc_pkg::*;
#(
  parameter logic [31:0] FW_VERSION = 32'h0000_0100
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register bus
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  // Panel, store and settings
  input  wire logic [1:0]  pll_unlock,
  input  wire logic        nv_wr_en,
  input  wire logic [5:0]  gain_att,
  input  wire logic        remote_on,
  input  wire logic        ext_ref_sel,
  input  wire logic        remote_mode,
  input  wire logic [4:0]  bus_addr,
  input  wire logic [10:0] disp_state,
  input  wire logic        power_lamp,
  input  wire logic        alarm_led,
  input  wire logic        remote_led
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Settings load just after reset, so stability is only judged later.
  logic [2:0] rel_cnt;
  logic       rd_ok;
  assign rd_ok = avs_read && !avs_waitrequest;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rel_cnt <= 3'h0;
    end else if (rel_cnt != 3'h7) begin
      rel_cnt <= rel_cnt + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  power_lamp_a: assert property ($past(nrst) |-> power_lamp)
    else $error("power lamp dark after reset");
  one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  unmapped_zero_a: assert property (rd_ok && avs_address > 5'h10 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  version_read_a: assert property (rd_ok && avs_address == REG_VERSION
    |-> avs_readdata == FW_VERSION) else $error("version read wrong");
  remote_lamp_a: assert property (remote_led == remote_on)
    else $error("remote lamp differs from remote setting");
  gain_range_a: assert property (gain_att <= GAIN_ATT_MAX)
    else $error("gain beyond range");
  store_pulse_a: assert property (nv_wr_en |=> !nv_wr_en)
    else $error("store strobe longer than one cycle");
  store_on_save_a: assert property (nv_wr_en |-> disp_state == ST_DONE)
    else $error("store outside save confirmation");
  settings_hold_a: assert property (rel_cnt == 3'h7 && disp_state != ST_DONE
    && $past(disp_state) != ST_DONE |-> $stable({remote_on, ext_ref_sel, remote_mode, bus_addr}))
    else $error("settings changed without save");
  alarm_lock_a: assert property ((pll_unlock != 2'h0) [*5] |=> alarm_led)
    else $error("alarm dark while loop unlocked");
endmodule : fpmc_top_properties

bind fpmc_top fpmc_top_properties #(.FW_VERSION(FW_VERSION)) props_i (
  .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pll_unlock(pll_unlock), .nv_wr_en(nv_wr_en), .gain_att(gain_att), .remote_on(remote_on),
  .ext_ref_sel(ext_ref_sel), .remote_mode(remote_mode), .bus_addr(bus_addr),
  .disp_state(disp_state), .power_lamp(power_lamp), .alarm_led(alarm_led),
  .remote_led(remote_led));

`default_nettype wire

// ### tb/fpmc_nv_model.sv
// Non-volatile settings store model that survives power cycles.
`timescale 1ns/1ps
`default_nettype none

module fpmc_nv_model
  import fpmc_pkg::*;
#(
  parameter logic [CFG_W-1:0] INIT = 14'h0405
) (
  // Clock
  input  wire logic             clk,
  // Store port
  input  wire logic             nv_wr_en,
  input  wire logic [CFG_W-1:0] nv_wr_data,
  output logic      [CFG_W-1:0] nv_rd_data
);
  // No reset input on purpose: the image must outlive a power cycle.
  logic [CFG_W-1:0] mem = INIT;

  always @(posedge clk) begin
    if (nv_wr_en === 1'b1) begin
      mem <= nv_wr_data;
    end
  end

  assign nv_rd_data = mem;
endmodule : fpmc_nv_model

`default_nettype wire

// ### tb/testbench.sv
// Self-checking testbench of the front panel menu controller.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import fpmc_pkg::*;
  // Version shown at power-up; the value is arbitrary.
  localparam logic [31:0] VER = 32'h0000_0100;
  logic             clk   = 1'b0;
  logic             nrst  = 1'b0;
  logic [4:0]       addr  = 5'h00;
  logic             rd    = 1'b0;
  logic             wr    = 1'b0;
  logic [31:0]      wdat  = 32'h0;
  logic [4:0]       sw    = 5'h00;
  logic [1:0]       pll   = 2'h0;
  logic [CFG_W-1:0] nv_rd;
  logic [CFG_W-1:0] nv_wd;
  logic             nv_we;
  logic [31:0]      rdat;
  logic             wreq;
  logic [5:0]       gain;
  logic             ron;
  logic [4:0]       badr;
  logic [10:0]      st;
  logic [1:0]       cur;
  logic             yes;
  logic             pwr;
  logic             alm;
  logic             rled;
  logic             xref;
  logic             rmod;
  logic [31:0]      q;
  int               errors    = 0;
  int               cmp_count = 0;
  int               wr_cnt    = 0;

  fpmc_top #(.SESSION_IDLE_CYCLES(200), .GAIN_IDLE_CYCLES(100), .BOOT_PHASE_CYCLES(8),
    .DEBOUNCE_CYCLES(4), .FW_VERSION(VER)) uut (
    .clk(clk), .nrst(nrst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .sw_commit(sw[SW_COMMIT]), .sw_left(sw[SW_LEFT]), .sw_right(sw[SW_RIGHT]),
    .sw_up(sw[SW_UP]), .sw_down(sw[SW_DOWN]), .pll_unlock(pll), .nv_rd_data(nv_rd),
    .nv_wr_en(nv_we), .nv_wr_data(nv_wd), .gain_att(gain), .remote_on(ron),
    .ext_ref_sel(xref), .remote_mode(rmod), .bus_addr(badr), .disp_state(st), .disp_cursor(cur),
    .disp_yes(yes), .power_lamp(pwr), .alarm_led(alm), .remote_led(rled));

  fpmc_nv_model nvm (.clk(clk), .nv_wr_en(nv_we), .nv_wr_data(nv_wd), .nv_rd_data(nv_rd));

  initial begin
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (nv_we === 1'b1) wr_cnt++;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // The request stands until the rising edge that samples waitrequest low.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr   <= w;
    rd   <= !w;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) errors++;
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  // Each level is held well past the debounce span plus synchroniser.
  task automatic press(input int i, input int n = 1);
    repeat (n) begin
      @(posedge clk);
      sw[i] <= 1'b1;
      repeat (12) @(posedge clk);
      sw[i] <= 1'b0;
      repeat (12) @(posedge clk);
    end
  endtask : press

  task automatic boot_up();
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(negedge clk);
    chk(st, ST_BOOT_SEG);
    repeat (8) @(negedge clk);
    chk(st, ST_BOOT_VER);
    repeat (8) @(negedge clk);
    chk(st, ST_BOOT_STAT);
    repeat (20) @(negedge clk);
    chk(st, ST_NORMAL);
  endtask : boot_up

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    boot_up();
    chk(gain, 6'h04);
    chk(badr, 5'h05);
    chk(pwr, 1'b1);
    $display("test boot done");
    bus(0, REG_VERSION, 0);
    chk(q, VER);
    bus(0, 5'h14, 0);
    chk(q, 0);
    bus(1, REG_SAVED, 32'hffff_ffff);
    bus(0, REG_SAVED, 0);
    chk(q, 32'h0405);
    bus(1, REG_CTRL, 1);
    press(SW_COMMIT);
    chk(st, ST_NORMAL);
    bus(1, REG_CTRL, 2);
    bus(0, REG_CTRL, 0);
    chk(q, 2);
    chk(alm, 1);
    bus(1, REG_CTRL, 0);
    $display("test bus done");
    press(SW_COMMIT);
    chk(st, ST_GAIN);
    press(SW_UP);
    chk(gain, 0);
    press(SW_DOWN, 3);
    chk(gain, 6'h28);
    press(SW_RIGHT);
    chk(cur, 1);
    press(SW_UP);
    chk(gain, 6'h26);
    press(SW_RIGHT);
    press(SW_UP);
    chk(gain, 6'h25);
    press(SW_LEFT);
    chk(cur, 1);
    press(SW_RIGHT, 2);
    press(SW_COMMIT);
    chk(st, ST_SAVE);
    chk(yes, 1);
    press(SW_DOWN);
    chk(yes, 0);
    press(SW_COMMIT);
    chk(gain, 6'h04);
    chk(wr_cnt, 0);
    press(SW_COMMIT);
    chk(st, ST_NORMAL);
    $display("test discard done");
    press(SW_COMMIT);
    press(SW_UP);
    press(SW_COMMIT);
    chk(st, ST_REMOTE);
    press(SW_UP);
    press(SW_DOWN);
    press(SW_UP);
    press(SW_COMMIT);
    chk(st, ST_EXTREF);
    press(SW_UP);
    press(SW_COMMIT);
    chk(st, ST_RMODE);
    press(SW_DOWN);
    press(SW_COMMIT);
    chk(st, ST_ADDR);
    press(SW_UP, 3);
    press(SW_RIGHT);
    press(SW_DOWN);
    press(SW_COMMIT);
    chk(st, ST_SAVE);
    press(SW_COMMIT);
    chk(wr_cnt, 1);
    chk(ron, 1);
    chk(rled, 1);
    chk(badr, 5'h1e);
    chk(xref, 1);
    chk(rmod, 1);
    chk(nvm.mem, 14'h00fe);
    press(SW_COMMIT);
    boot_up();
    chk(gain, 0);
    chk(badr, 5'h1e);
    chk(ron, 1);
    chk(xref, 1);
    chk(rmod, 1);
    $display("test save done");
    press(SW_COMMIT);
    press(SW_DOWN);
    chk(gain, 6'h14);
    repeat (100) @(negedge clk);
    chk(st, ST_NORMAL);
    chk(gain, 0);
    press(SW_COMMIT);
    press(SW_DOWN);
    press(SW_COMMIT);
    press(SW_UP);
    repeat (100) @(negedge clk);
    chk(st, ST_REMOTE);
    chk(gain, 6'h14);
    repeat (100) @(negedge clk);
    chk(st, ST_NORMAL);
    chk(gain, 0);
    chk(ron, 1);
    $display("test timeout done");
    @(posedge clk);
    pll <= 2'h2;
    repeat (8) @(negedge clk);
    chk(alm, 1);
    @(posedge clk);
    pll <= 2'h0;
    repeat (8) @(negedge clk);
    chk(alm, 0);
    $display("test alarm done");
    end_of_test();
  end

  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
